// ### hw/twdr_pkg.sv
package twdr_pkg;
  // track counts
  localparam int NUM_DATA = 9;
  localparam int CELLS_PER_UNIT = 2;
  // timing, clock 250 MHz
  localparam int CLK_MHZ = 250;
  localparam real STEP_US = 1.5;
  localparam int STEP_CYC = int'(STEP_US * CLK_MHZ);
  localparam real DLY_DEF_US = 10.0;
  localparam real DLY_MIN_US = 4.0;
  localparam real DLY_MAX_US = 25.0;
  localparam int DLY_DEF_CYC = int'(DLY_DEF_US * CLK_MHZ);
  localparam int DLY_MIN_CYC = int'(DLY_MIN_US * CLK_MHZ);
  localparam int DLY_MAX_CYC = int'(DLY_MAX_US * CLK_MHZ);
  localparam int CNT_W = 13;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;

  // one recovered word: data bits plus frame sync
  typedef struct packed {
    logic [NUM_DATA-1:0] data;
    logic fsync;
  } twdr_word_s;
  localparam int WORD_W = NUM_DATA + 1;

  // sequencer states, gray from idle to transfer; the return to idle flips two bits
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_WAIT = 3'b001,
    TW_CLR = 3'b011,
    TW_DMX = 3'b010,
    TW_XFR = 3'b110
  } twdr_state_e;
endpackage : twdr_pkg

// ### hw/twdr_fifo.sv
`timescale 1ns/1ns
module twdr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, rp_r;
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push = in_valid && !full;
  wire pop = out_valid && out_ready;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rp_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end
endmodule : twdr_fifo

// ### hw/twdr_top.sv
`timescale 1ns/1ns
module twdr_top
  import twdr_pkg::*;
#(
  parameter int DELAY_CYC = DLY_DEF_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // track pulses from reproduce amplifiers
  input wire logic [NUM_DATA-1:0] DATA_TRK,
  input wire logic FSYNC_TRK,
  input wire logic CLK_TRK,
  // converter side
  output logic DAC_CLEAR,
  output logic [NUM_DATA-1:0] DAC_WORD,
  output logic DAC_LOAD,
  // demultiplexer side
  output logic DMX_CLOCK,
  output logic DMX_FSYNC,
  // buffered word stream
  output logic WORD_VALID,
  input wire logic WORD_READY,
  output logic [WORD_W-1:0] WORD_DATA,
  output logic OVERRUN
);
  // counter width bounds the delay; the step must leave room for the
  // one-cycle shorter second wait
  if (DELAY_CYC < 1 || DELAY_CYC >= (1 << CNT_W) ||
      STEP_CYC < 2) begin : g_bad_cfg
    $error("bad delay");
  end
  localparam int NTRK = NUM_DATA + 1;
  localparam int NUNIT = (NTRK + CELLS_PER_UNIT - 1) / CELLS_PER_UNIT;
  localparam logic [CNT_W-1:0] DLY_C = DELAY_CYC[CNT_W-1:0];
  localparam logic [CNT_W-1:0] STEP_C = STEP_CYC[CNT_W-1:0];

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [NTRK:0] s1_r, s2_r, s3_r;
  wire [NTRK:0] pins = {CLK_TRK, FSYNC_TRK, DATA_TRK};
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // one strobe per detected pulse, leading edge only
  // third stage only remembers the old level for the edge finder
  wire [NTRK:0] rise = s2_r & ~s3_r;
  wire [NTRK-1:0] set_stb = rise[NTRK-1:0];
  wire clk_stb = rise[NTRK];

  ////////////////////////////////////////////////////////////////////
  // sequencer
  twdr_state_e st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  wire cnt_done = (cnt_r == CNT_ONE);
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - CNT_ONE;
    case (st_r)
      TW_IDLE: begin
        if (clk_stb) begin
          st_nxt = TW_WAIT;
          cnt_nxt = DLY_C;
        end
      end
      // wait covers track skew; a clock pulse here is ignored
      TW_WAIT: begin
        if (cnt_done) begin
          st_nxt = TW_CLR;
          cnt_nxt = STEP_C;
        end
      end
      TW_CLR: begin
        if (cnt_done) begin
          st_nxt = TW_DMX;
          // the transfer state itself costs one cycle, so wait one less
          cnt_nxt = STEP_C - CNT_ONE;
        end
      end
      TW_DMX: begin
        if (cnt_done) begin
          st_nxt = TW_XFR;
          cnt_nxt = CNT_ONE;
        end
      end
      TW_XFR: begin
        st_nxt = TW_IDLE;
        cnt_nxt = CNT_ONE;
      end
      default: begin
        st_nxt = TW_IDLE;
        cnt_nxt = CNT_ONE;
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_r <= TW_IDLE;
      cnt_r <= CNT_ONE;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // one-cycle pulses at each step entry
  wire go_clr = (st_r == TW_WAIT) && cnt_done;
  wire go_dmx = (st_r == TW_CLR) && cnt_done;
  wire xfr = (st_r == TW_XFR);

  ////////////////////////////////////////////////////////////////////
  // track stores, two cells per unit
  // each cell is its own flip-flop; the vector only gathers them
  wire [NTRK-1:0] cell_r;
  genvar u, c;
  generate
    for (u = 0; u < NUNIT; u++) begin : g_unit
      for (c = 0; c < CELLS_PER_UNIT; c++) begin : g_cell
        localparam int K = u * CELLS_PER_UNIT + c;
        if (K < NTRK) begin : g_used
          logic bit_r;
          always_ff @(posedge CLK) begin
            if (!RST_B) bit_r <= 1'b0;
            else if (xfr) bit_r <= set_stb[K];
            else if (set_stb[K]) bit_r <= 1'b1;
          end
          assign cell_r[K] = bit_r;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // outputs
  twdr_word_s word_w;
  assign word_w.data = cell_r[NUM_DATA-1:0];
  assign word_w.fsync = cell_r[NUM_DATA];
  wire f_ready;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      DAC_CLEAR <= 1'b0;
      DMX_CLOCK <= 1'b0;
      DAC_LOAD <= 1'b0;
      DAC_WORD <= '0;
      DMX_FSYNC <= 1'b0;
      OVERRUN <= 1'b0;
    end else begin
      DAC_CLEAR <= go_clr;
      DMX_CLOCK <= go_dmx;
      DAC_LOAD <= xfr;
      if (go_clr) DAC_WORD <= '0;
      else if (xfr) DAC_WORD <= word_w.data;
      DMX_FSYNC <= xfr && word_w.fsync;
      OVERRUN <= xfr && !f_ready;
    end
  end
  // fifo gives a consumer slack; a full fifo drops and flags the word
  // since tape cannot be stalled
  wire [WORD_W-1:0] f_q;
  wire f_v;
  twdr_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst_b(RST_B),
    .in_valid(xfr),
    .in_ready(f_ready),
    .in_data(word_w),
    .out_valid(f_v),
    // pop exactly when the output stage loads, so no word goes out twice
    .out_ready(!WORD_VALID),
    .out_data(f_q)
  );
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      WORD_VALID <= 1'b0;
      WORD_DATA <= '0;
    end else if (!WORD_VALID || WORD_READY) begin
      WORD_VALID <= f_v && !WORD_VALID;
      if (f_v && !WORD_VALID) WORD_DATA <= f_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions
  property p_clr_zero;
    @(posedge CLK) disable iff (!RST_B) DAC_CLEAR |-> DAC_WORD == '0;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear not zero");
  property p_hold;
    @(posedge CLK) disable iff (!RST_B)
      $past(cell_r[0]) && !$past(xfr) |-> cell_r[0];
  endproperty
  a_hold: assert property (p_hold) else $error("store lost bit");
  property p_nozero;
    @(posedge CLK) disable iff (!RST_B)
      !$past(cell_r[1]) && !$past(set_stb[1]) |-> !cell_r[1];
  endproperty
  a_nozero: assert property (p_nozero) else $error("spurious set");
  property p_reset;
    @(posedge CLK) disable iff (!RST_B)
      xfr && set_stb == '0 |=> cell_r == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("no reset");
  // cycles since the last step pulse; saturates so a long idle never wraps
  logic [CNT_W-1:0] gap_r;
  always_ff @(posedge CLK) begin
    if (!RST_B) gap_r <= CNT_ZERO;
    else if (go_clr || go_dmx) gap_r <= CNT_ONE;
    else if (gap_r != '1) gap_r <= gap_r + CNT_ONE;
  end
  property p_step;
    @(posedge CLK) disable iff (!RST_B) (go_dmx || xfr) |-> gap_r == STEP_C;
  endproperty
  a_step: assert property (p_step) else $error("bad spacing");
  property p_order;
    @(posedge CLK) disable iff (!RST_B) DMX_CLOCK |-> $past(st_r) == TW_CLR;
  endproperty
  a_order: assert property (p_order) else $error("bad order");
  property p_word;
    @(posedge CLK) disable iff (!RST_B)
      xfr |=> DAC_LOAD && DAC_WORD == $past(cell_r[NUM_DATA-1:0]);
  endproperty
  a_word: assert property (p_word) else $error("word mismatch");
  property p_fs;
    @(posedge CLK) disable iff (!RST_B)
      DMX_FSYNC |-> DAC_LOAD && $past(cell_r[NUM_DATA]);
  endproperty
  a_fs: assert property (p_fs) else $error("fsync mismatch");
  property p_coin;
    @(posedge CLK) disable iff (!RST_B) xfr && set_stb[0] |=> cell_r[0];
  endproperty
  a_coin: assert property (p_coin) else $error("set lost");
  property p_enter;
    @(posedge CLK) disable iff (!RST_B)
      (st_r == TW_IDLE) && clk_stb |=> (st_r == TW_WAIT) && cnt_r == DLY_C;
  endproperty
  a_enter: assert property (p_enter) else $error("bad start delay");
  // a clock pulse inside a running sequence must not restart it
  property p_ignore;
    @(posedge CLK) disable iff (!RST_B)
      (st_r != TW_IDLE) && (st_r != TW_WAIT) && clk_stb |=> st_r != TW_WAIT;
  endproperty
  a_ignore: assert property (p_ignore) else $error("restarted");
  property p_apart;
    @(posedge CLK) disable iff (!RST_B) DAC_CLEAR |-> !DMX_CLOCK && !DAC_LOAD;
  endproperty
  a_apart: assert property (p_apart) else $error("pulses overlap");
  property p_dmx_clear;
    @(posedge CLK) disable iff (!RST_B) DMX_CLOCK |-> DAC_WORD == '0;
  endproperty
  a_dmx_clear: assert property (p_dmx_clear) else $error("not cleared");
  property p_one_clr;
    @(posedge CLK) disable iff (!RST_B) DAC_CLEAR |=> !DAC_CLEAR;
  endproperty
  a_one_clr: assert property (p_one_clr) else $error("long clear");
  property p_one_load;
    @(posedge CLK) disable iff (!RST_B) DAC_LOAD |=> !DAC_LOAD;
  endproperty
  a_one_load: assert property (p_one_load) else $error("long load");
  property p_ovr;
    @(posedge CLK) disable iff (!RST_B) OVERRUN |-> DAC_LOAD;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun off transfer");
  // tape cannot wait, but the stream side must hold still for its consumer
  property p_stream;
    @(posedge CLK) disable iff (!RST_B)
      WORD_VALID && !WORD_READY |=> WORD_VALID && $stable(WORD_DATA);
  endproperty
  a_stream: assert property (p_stream) else $error("stream dropped");
  c_seq: cover property (@(posedge CLK) disable iff (!RST_B)
    (xfr && gap_r == STEP_C) ##1 DAC_LOAD);
  c_coin: cover property (@(posedge CLK) disable iff (!RST_B)
    xfr && set_stb != '0);
  c_fs: cover property (@(posedge CLK) disable iff (!RST_B) DMX_FSYNC);
  c_ovr: cover property (@(posedge CLK) disable iff (!RST_B) OVERRUN);
endmodule : twdr_top

// ### verif/twdr_tape_model.sv
`timescale 1ns/1ns
module twdr_tape_model
  import twdr_pkg::*;
(
  // bench clock, used only to pace the pulses
  input wire logic clk,
  // reproduce amplifier outputs
  output logic [NUM_DATA-1:0] data_trk,
  output logic fsync_trk,
  output logic clk_trk
);
  // idle tracks stand still low: no flux change, no pulse
  initial begin
    data_trk = '0;
    fsync_trk = 1'h0;
    clk_trk = 1'h0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  //////////////////////////////////////////////////////////////////////////
  // one word per call; data bits 4 to 7 and frame sync lead the clock track, data bits 0 to 3 and 8 trail
  // it, so the stores must cover skew both ways
  task automatic send_word(input twdr_word_s w, input logic extra);
    data_trk = w.data & 9'h0f0;
    fsync_trk = w.fsync;
    hold(20);
    data_trk = '0;
    fsync_trk = 1'h0;
    hold(20);
    clk_trk = 1'h1;
    hold(20);
    clk_trk = 1'h0;
    data_trk = w.data & 9'h10f;
    hold(20);
    data_trk = '0;
    if (extra) begin
      // a stray clock pulse while the sequence still runs
      hold(100);
      clk_trk = 1'h1;
      hold(20);
      clk_trk = 1'h0;
    end
  endtask : send_word

  // a lone pulse on one data track after a given number of cycles
  task automatic strobe(input int idx, input int n);
    hold(n);
    data_trk[idx] = 1'h1;
    hold(20);
    data_trk = '0;
  endtask : strobe
endmodule : twdr_tape_model

// ### verif/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import twdr_pkg::*;
;
  localparam int DLY = 50;
  // roughly twenty words of about 900 cycles each, with margin
  localparam int LIMIT = 40000;
  logic clk, rst_b, clk_trk, fsync_trk, word_ready;
  logic [NUM_DATA-1:0] data_trk;
  logic dac_clear, dac_load, dmx_clock, dmx_fsync, word_valid, overrun;
  logic [NUM_DATA-1:0] dac_word;
  logic [WORD_W-1:0] word_data;
  int errors = 0, total_checks = 0, cyc = 0, ovr_cnt = 0, clr_cnt = 0, n0;
  logic [WORD_W-1:0] rxq[$];
  twdr_word_s rows [5] = '{'{9'h1ff, 1'h1}, '{9'h000, 1'h0},
    '{9'h155, 1'h0}, '{9'h0aa, 1'h1}, '{9'h100, 1'h1}};

  twdr_top #(.DELAY_CYC(DLY)) twdr_top_inst (.CLK(clk), .RST_B(rst_b),
    .DATA_TRK(data_trk), .FSYNC_TRK(fsync_trk), .CLK_TRK(clk_trk),
    .DAC_CLEAR(dac_clear), .DAC_WORD(dac_word), .DAC_LOAD(dac_load),
    .DMX_CLOCK(dmx_clock), .DMX_FSYNC(dmx_fsync), .WORD_VALID(word_valid),
    .WORD_READY(word_ready), .WORD_DATA(word_data), .OVERRUN(overrun));
  twdr_tape_model twdr_tape_model_inst (.clk(clk), .data_trk(data_trk),
    .fsync_trk(fsync_trk), .clk_trk(clk_trk));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (overrun === 1'h1) ovr_cnt++;
    if (dac_clear === 1'h1) clr_cnt++;
    if (word_valid === 1'h1 && word_ready === 1'h1) rxq.push_back(word_data);
    if (cyc == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_pulse(input int sel, output int n);
    n = 0;
    while (!((sel == 0) ? dac_clear : (sel == 1) ? dmx_clock : dac_load)
           && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_pulse

  task automatic do_word(input twdr_word_s w, input logic extra);
    int n;
    fork
      twdr_tape_model_inst.send_word(w, extra);
    join_none
    wait_pulse(0, n);
    chk("delay", 16'h1, 16'(n >= DLY + 42 && n <= DLY + 46));
    wait_pulse(1, n);
    chk("clr_to_dmx", 16'(STEP_CYC), 16'(n));
    chk("dac_cleared", 16'h0, 16'(dac_word));
    wait_pulse(2, n);
    chk("dmx_to_load", 16'(STEP_CYC), 16'(n));
    chk("dac_word", 16'(w.data), 16'(dac_word));
    chk("dmx_fsync", 16'(w.fsync), 16'(dmx_fsync));
    repeat (10) @(posedge clk);
    #1;
  endtask : do_word

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'h0;
    word_ready = 1'h1;
    repeat (10) @(posedge clk);
    #1;
    chk("rst_word", 16'h0, 16'(dac_word));
    chk("rst_valid", 16'h0, 16'(word_valid));
    rst_b = 1'h1;
    $display("test reset done");
    foreach (rows[i]) do_word(rows[i], 1'h0);
    chk("rx_count", 16'h5, 16'(rxq.size()));
    foreach (rows[i]) chk("rx_word", 16'(rows[i]), 16'(rxq[i]));
    $display("test rows done");
    n0 = clr_cnt;
    do_word(rows[2], 1'h1);
    repeat (900) @(posedge clk);
    #1;
    chk("stray_clock", 16'h1, 16'(clr_cnt - n0));
    $display("test stray clock done");
    fork
      twdr_tape_model_inst.send_word(rows[1], 1'h0);
    join_none
    wait_pulse(1, n0);
    // pin two cycles ahead of the transfer: the sync chain eats two
    twdr_tape_model_inst.strobe(0, STEP_CYC - 3);
    chk("coin_now", 16'h0, 16'(dac_word));
    fork
      twdr_tape_model_inst.send_word(rows[1], 1'h0);
    join_none
    wait_pulse(2, n0);
    chk("coin_next", 16'h1, 16'(dac_word));
    repeat (10) @(posedge clk);
    #1;
    $display("test coincident set done");
    rxq.delete();
    word_ready = 1'h0;
    // eight in the fifo plus one in the output stage; the tenth drops
    for (int i = 0; i < 10; i++) do_word('{9'(i + 1), 1'(i)}, 1'h0);
    chk("overrun", 16'h1, 16'(ovr_cnt));
    word_ready = 1'h1;
    repeat (40) @(posedge clk);
    #1;
    chk("drain", 16'h9, 16'(rxq.size()));
    chk("first", {9'h001, 1'h0}, 16'(rxq[0]));
    chk("last", {9'h009, 1'h0}, 16'(rxq[8]));
    $display("test fifo fill done");
    fork
      twdr_tape_model_inst.send_word(rows[0], 1'h0);
    join_none
    repeat (120) @(posedge clk);
    #1;
    rst_b = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("mid_rst_word", 16'h0, 16'(dac_word));
    chk("mid_rst_valid", 16'h0, 16'(word_valid));
    rst_b = 1'h1;
    repeat (900) @(posedge clk);
    #1;
    do_word(rows[3], 1'h0);
    $display("test mid reset done");
    complete_run();
  end
endmodule : tb_top
